//--- src/hmn_pkg.sv
package hmn_pkg;

  // ==========================================================
  // opcode fields and patterns
  localparam int          HMN_OP_W        = 16;
  localparam int          HMN_RD_LSB      = 0;
  localparam int          HMN_FILE_BIT    = 4;
  localparam int          HMN_RS_LSB      = 5;
  localparam int          HMN_REG_NUM_W   = 4;
  localparam logic [6:0]  HMN_LOW_HALF_COPY_TOP  = 7'h76;  // bits 15:9 = 1110110
  localparam logic [6:0]  HMN_HIGH_HALF_COPY_TOP = 7'h77;  // 1110111
  localparam logic [6:0]  HMN_SIGNED_MULTIPLY_TOP   = 7'h2e; // 0101110
  localparam logic [6:0]  HMN_UNSIGNED_MULTIPLY_TOP = 7'h2f; // 0101111
  localparam logic [10:0] HMN_TWOS_COMPLEMENT_TOP   = 11'h01d; // 00000011101
  localparam logic [10:0] HMN_COMPLEMENT_BORROW_TOP = 11'h01e; // 00000011110
  localparam logic [15:0] HMN_IDLE_INSTRUCTION      = 16'h0300;

  // ==========================================================
  // data and timing
  localparam int          HMN_DATA_W      = 32;
  localparam int          HMN_HALF_W      = 16;
  localparam logic [31:0] HMN_MOST_NEG    = 32'h8000_0000;
  localparam logic [5:0]  HMN_MUL_SHORT_BASE = 6'h05;
  localparam logic [5:0]  HMN_MUL_LONG_BASE  = 6'h08;
  localparam logic [5:0]  HMN_MUL_NEG_EXTRA  = 6'h01;
  localparam logic [5:0]  HMN_SINGLE_STATE   = 6'h01;

  typedef enum logic [2:0] {
    HMN_OP_NONE  = 3'h0,
    HMN_OP_LOWX  = 3'h1,
    HMN_OP_HIGHY = 3'h2,
    HMN_OP_SIGNED_MULTIPLY  = 3'h3,
    HMN_OP_UNSIGNED_MULTIPLY  = 3'h4,
    HMN_OP_NEG   = 3'h5,
    HMN_OP_COMPLEMENT_WITH_BORROW  = 3'h6,
    HMN_OP_IDLE  = 3'h7
  } hmn_op_t;

  typedef struct packed {
    logic       n;
    logic       c;
    logic       z;
    logic       v;
  } hmn_flags_t;

  // register file write-back
  typedef struct packed {
    logic        en;
    logic        file_b;
    logic [3:0]  num;
    logic [31:0] data;
  } hmn_wr_t;

  typedef struct packed {
    hmn_op_t     op;
    logic        file_b;
    logic [3:0]  rs;
    logic [3:0]  rd;
  } hmn_dec_t;

endpackage

//--- src/hmn_decode.sv
`timescale 1ns/1ps
module hmn_decode
  import hmn_pkg::*;
(
  // opcode in
  input  wire logic [15:0]         opcode_i,
  // decoded fields
  output hmn_pkg::hmn_dec_t        dec_o
);
  import hmn_pkg::*;

  // ==========================================================
  // field split and opcode match
  always_comb
  begin
    dec_o.rs     = opcode_i[HMN_RS_LSB +: HMN_REG_NUM_W];
    dec_o.file_b = opcode_i[HMN_FILE_BIT];
    dec_o.rd     = opcode_i[HMN_RD_LSB +: HMN_REG_NUM_W];
    if (opcode_i == HMN_IDLE_INSTRUCTION)
      dec_o.op = HMN_OP_IDLE;
    else if (opcode_i[15:9] == HMN_LOW_HALF_COPY_TOP)
      dec_o.op = HMN_OP_LOWX;
    else if (opcode_i[15:9] == HMN_HIGH_HALF_COPY_TOP)
      dec_o.op = HMN_OP_HIGHY;
    else if (opcode_i[15:9] == HMN_SIGNED_MULTIPLY_TOP)
      dec_o.op = HMN_OP_SIGNED_MULTIPLY;
    else if (opcode_i[15:9] == HMN_UNSIGNED_MULTIPLY_TOP)
      dec_o.op = HMN_OP_UNSIGNED_MULTIPLY;
    else if (opcode_i[15:5] == HMN_TWOS_COMPLEMENT_TOP)
      dec_o.op = HMN_OP_NEG;
    else if (opcode_i[15:5] == HMN_COMPLEMENT_BORROW_TOP)
      dec_o.op = HMN_OP_COMPLEMENT_WITH_BORROW;
    else
      dec_o.op = HMN_OP_NONE;
  end

endmodule

//--- src/hmn_multiply.sv
`timescale 1ns/1ps
module hmn_multiply
  import hmn_pkg::*;
(
  // operands
  input  wire logic [31:0] multiplicand_i,
  input  wire logic [31:0] src_reg_i,
  input  wire logic [5:0]  width_i,
  input  wire logic        signed_i,
  // product
  output logic      [63:0] product_o
);
  import hmn_pkg::*;

  logic [31:0] field;
  logic        field_sign;
  logic signed [32:0] mcand_ext;
  logic signed [32:0] mplier_ext;
  logic signed [65:0] full;

  // ==========================================================
  // n-bit multiplier field, sign or zero extended
  always_comb
  begin
    field      = 32'h0000_0000;
    field_sign = 1'b0;
    for (int i = 0; i < HMN_DATA_W; i++)
    begin
      if (i < int'(width_i))
        field[i] = src_reg_i[i];
      if (i == int'(width_i) - 1)
        field_sign = src_reg_i[i];
    end
    for (int i = 0; i < HMN_DATA_W; i++)
      if (i >= int'(width_i))
        field[i] = signed_i & field_sign;
    mplier_ext = {signed_i & field_sign, field};
    mcand_ext  = {signed_i & multiplicand_i[31], multiplicand_i};
    full       = mcand_ext * mplier_ext;
    product_o  = full[63:0];
  end

endmodule

//--- src/hmn_unit.sv
`timescale 1ns/1ps
// Contract
// - low copy writes bits 15:0 only
// - high copy writes bits 31:16 only
// - half copies keep all four flags
// - one file bit serves both operands
// - signed multiply: 32-bit multiplicand, n-bit multiplier
// - width is setting, even 2 to 32
// - source bit n-1 is sign, upper ignored
// - even destination takes 64-bit product pair
// - odd destination takes low word only
// - multiply takes 5 or 8 plus n/2
// - signed multiply sets negative and zero only
// - unsigned multiply zero-extends both operands
// - unsigned negative source adds one state
// - unsigned multiply updates zero flag only
// - negate: carry nonzero, overflow at most-negative
// - negate with borrow subtracts incoming carry
// - idle only advances program counter
module hmn_unit
  import hmn_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  // instruction issue
  input  wire logic                    issue_i,
  input  wire logic [15:0]             opcode_i,
  input  wire logic                    long_case_i,
  input  wire logic [5:0]              multiplier_width_setting_i,
  // operands read by the decoder
  input  wire logic [DATA_W-1:0]       src_reg_i,
  input  wire logic [DATA_W-1:0]       dst_reg_i,
  input  hmn_pkg::hmn_flags_t          flags_i,
  // decoded register numbers for operand fetch
  output hmn_pkg::hmn_dec_t            dec_o,
  // results
  output hmn_pkg::hmn_wr_t             wr_a_o,
  output hmn_pkg::hmn_wr_t             wr_b_o,
  output logic                         flags_we_o,
  output hmn_pkg::hmn_flags_t          flags_o,
  output logic                         pc_advance_o,
  output logic                         busy_o,
  output logic                         done_o,
  output logic [5:0]                   states_o
);
  import hmn_pkg::*;

  typedef enum logic [1:0] {
    HMN_IDLE = 2'b00,
    HMN_WAIT = 2'b01,
    HMN_LAST = 2'b11
  } hmn_state_t;

  hmn_dec_t     dec;
  hmn_state_t   state;
  hmn_state_t   next_state;
  logic [5:0]   count;
  logic [5:0]   next_count;
  logic [5:0]   cost;
  logic [63:0]  product;
  logic [31:0]  negated;
  logic         neg_borrow;
  logic         neg_ovf;
  hmn_wr_t      res_a;
  hmn_wr_t      res_b;
  hmn_flags_t   res_flags;
  logic         res_flags_we;
  logic         is_mul;
  logic [31:0]  mul_store;

  // ==========================================================
  // decode and multiply sub-blocks
  hmn_decode u_decode (
    .opcode_i (opcode_i),
    .dec_o    (dec)
  );

  hmn_multiply u_multiply (
    .multiplicand_i (dst_reg_i[31:0]),
    .src_reg_i      (src_reg_i[31:0]),
    .width_i        (multiplier_width_setting_i),
    .signed_i       (dec.op == HMN_OP_SIGNED_MULTIPLY),
    .product_o      (product)
  );

  function automatic logic is_zero(input logic [31:0] v);
    is_zero = (v == 32'h0000_0000);
  endfunction

  // ==========================================================
  // negate arithmetic: 0 - rd - borrow, 33 bits to catch borrow out
  always_comb
  begin
    logic [32:0] diff;
    diff       = 33'h0_0000_0000;
    diff       = 33'h0_0000_0000 - {1'b0, dst_reg_i[31:0]}
                 - {32'h0000_0000, (dec.op == HMN_OP_COMPLEMENT_WITH_BORROW) & flags_i.c};
    negated    = diff[31:0];
    neg_borrow = diff[32];
    neg_ovf    = dst_reg_i[31] & negated[31];
  end

  // ==========================================================
  // state count for the issued instruction
  always_comb
  begin
    is_mul = (dec.op == HMN_OP_SIGNED_MULTIPLY) || (dec.op == HMN_OP_UNSIGNED_MULTIPLY);
    if (is_mul)
    begin
      cost = (long_case_i ? HMN_MUL_LONG_BASE : HMN_MUL_SHORT_BASE)
             + {1'b0, multiplier_width_setting_i[5:1]};
      if (dec.op == HMN_OP_UNSIGNED_MULTIPLY && src_reg_i[31])
        cost = cost + HMN_MUL_NEG_EXTRA;
    end
    else
      cost = HMN_SINGLE_STATE;
  end

  // ==========================================================
  // result selection
  always_comb
  begin
    res_a        = '0;
    res_b        = '0;
    res_flags    = flags_i;
    res_flags_we = 1'b0;
    mul_store    = dec.rd[0] ? product[31:0] : product[63:32];
    res_a.file_b = dec.file_b;
    res_b.file_b = dec.file_b;
    res_a.num    = dec.rd;
    res_b.num    = dec.rd | 4'h1;
    case (dec.op)
      HMN_OP_LOWX:
      begin
        res_a.en   = 1'b1;
        res_a.data = {dst_reg_i[31:16], src_reg_i[15:0]};
      end
      HMN_OP_HIGHY:
      begin
        res_a.en   = 1'b1;
        res_a.data = {src_reg_i[31:16], dst_reg_i[15:0]};
      end
      HMN_OP_SIGNED_MULTIPLY,
      HMN_OP_UNSIGNED_MULTIPLY:
      begin
        res_a.en   = 1'b1;
        res_a.data = mul_store;
        res_b.en   = ~dec.rd[0];
        res_b.data = product[31:0];
        res_flags_we = 1'b1;
        if (dec.rd[0])
          res_flags.z = is_zero(product[31:0]);
        else
          res_flags.z = is_zero(product[63:32]) & is_zero(product[31:0]);
        if (dec.op == HMN_OP_SIGNED_MULTIPLY)
          res_flags.n = dec.rd[0] ? product[31] : product[63];
        // carry and overflow keep their values
      end
      HMN_OP_NEG,
      HMN_OP_COMPLEMENT_WITH_BORROW:
      begin
        res_a.en     = 1'b1;
        res_a.data   = negated;
        res_flags_we = 1'b1;
        res_flags.n  = negated[31];
        res_flags.z  = is_zero(negated);
        res_flags.c  = neg_borrow;
        res_flags.v  = neg_ovf;
      end
      default:
      begin
        // half copies and idle leave flags alone
        res_flags_we = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // sequencer
  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      HMN_IDLE:
        if (issue_i && dec.op != HMN_OP_NONE)
        begin
          next_count = cost - HMN_SINGLE_STATE;
          next_state = (cost == HMN_SINGLE_STATE) ? HMN_LAST : HMN_WAIT;
        end
      HMN_WAIT:
      begin
        next_count = count - HMN_SINGLE_STATE;
        if (count == HMN_SINGLE_STATE)
          next_state = HMN_LAST;
      end
      HMN_LAST:
        next_state = HMN_IDLE;
      default:
        next_state = HMN_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= HMN_IDLE;
      count <= 6'h00;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  // ==========================================================
  // captured result, held stable while the multiply counts
  hmn_wr_t     held_a;
  hmn_wr_t     held_b;
  hmn_flags_t  held_flags;
  logic        held_flags_we;
  logic        held_pc;
  hmn_dec_t    held_dec;
  logic [5:0]  held_cost;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      held_a        <= '0;
      held_b        <= '0;
      held_flags    <= '0;
      held_flags_we <= 1'b0;
      held_pc       <= 1'b0;
      held_dec      <= '0;
      held_cost     <= 6'h00;
    end
    else if (state == HMN_IDLE && issue_i && dec.op != HMN_OP_NONE)
    begin
      held_a        <= res_a;
      held_b        <= res_b;
      held_flags    <= res_flags;
      held_flags_we <= res_flags_we;
      held_pc       <= 1'b1;
      held_dec      <= dec;
      held_cost     <= cost;
    end
  end

  // ==========================================================
  // registered outputs, one-cycle result strobe
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_a_o       <= '0;
      wr_b_o       <= '0;
      flags_we_o   <= 1'b0;
      flags_o      <= '0;
      pc_advance_o <= 1'b0;
      done_o       <= 1'b0;
      states_o     <= 6'h00;
    end
    else
    begin
      wr_a_o       <= '0;
      wr_b_o       <= '0;
      flags_we_o   <= 1'b0;
      pc_advance_o <= 1'b0;
      done_o       <= 1'b0;
      if (state == HMN_LAST)
      begin
        wr_a_o       <= held_a;
        wr_b_o       <= held_b;
        flags_we_o   <= held_flags_we;
        flags_o      <= held_flags;
        pc_advance_o <= held_pc;
        done_o       <= 1'b1;
        states_o     <= held_cost;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      busy_o <= 1'b0;
    else
      busy_o <= (next_state != HMN_IDLE);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      dec_o <= '0;
    else
      dec_o <= dec;
  end

endmodule

//--- sim/hmn_unit_props.sv
`timescale 1ns/1ps
module hmn_unit_props
  import hmn_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // issue side
  input  wire logic              issue_i,
  input  wire logic [15:0]       opcode_i,
  input  wire logic              long_case_i,
  input  wire logic [5:0]        multiplier_width_setting_i,
  input  wire logic [DATA_W-1:0] src_reg_i,
  input  wire logic [DATA_W-1:0] dst_reg_i,
  input  hmn_pkg::hmn_flags_t    flags_i,
  // result side
  input  hmn_pkg::hmn_dec_t      dec_o,
  input  hmn_pkg::hmn_wr_t       wr_a_o,
  input  hmn_pkg::hmn_wr_t       wr_b_o,
  input  wire logic              flags_we_o,
  input  hmn_pkg::hmn_flags_t    flags_o,
  input  wire logic              pc_advance_o,
  input  wire logic              busy_o,
  input  wire logic              done_o,
  input  wire logic [5:0]        states_o
);
  logic       is_lo, is_hi, is_mul, is_neg, is_idle, acc, mul_q, uns_q;
  logic [3:0] rd_q;
  logic [5:0] k_q, cnt;
  hmn_flags_t fl_q;
  assign is_lo   = opcode_i[15:9] == HMN_LOW_HALF_COPY_TOP;
  assign is_hi   = opcode_i[15:9] == HMN_HIGH_HALF_COPY_TOP;
  assign is_mul  = opcode_i[15:10] == HMN_SIGNED_MULTIPLY_TOP[6:1];
  assign is_neg  = opcode_i[15:5] == HMN_TWOS_COMPLEMENT_TOP;
  assign is_idle = opcode_i == HMN_IDLE_INSTRUCTION;
  assign acc     = issue_i && !busy_o && (is_lo || is_hi || is_mul || is_neg || is_idle
                   || opcode_i[15:5] == HMN_COMPLEMENT_BORROW_TOP);
  // ==========================================================
  // capture of each accepted instruction and its elapsed edges
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mul_q <= 1'b0;
      uns_q <= 1'b0;
      rd_q  <= 4'h0;
      fl_q  <= '0;
      k_q   <= 6'h00;
      cnt   <= 6'h00;
    end
    else if (acc)
    begin
      mul_q <= is_mul;
      uns_q <= opcode_i[9];
      rd_q  <= opcode_i[3:0];
      fl_q  <= flags_i;
      k_q   <= (long_case_i ? HMN_MUL_LONG_BASE : HMN_MUL_SHORT_BASE) + (multiplier_width_setting_i >> 1)
               + {5'h00, opcode_i[9] & src_reg_i[DATA_W-1]};
      cnt   <= 6'h01;
    end
    else if (cnt != 6'h3f)
      cnt <= cnt + 6'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // properties
  mul_cost_time_a: assert property (done_o && mul_q |-> cnt == k_q + 6'h01 && states_o == k_q)
    else $error("multiply cost or completion time wrong");
  mul_pair_dest_a: assert property (done_o && mul_q |-> wr_a_o.en && wr_a_o.num == rd_q
    && wr_b_o.en == !rd_q[0] && (rd_q[0] || wr_b_o.num == (rd_q | 4'h1))) else $error("multiply write-back wrong");
  mul_flag_keep_a: assert property (done_o && mul_q && flags_we_o |-> flags_o.c == fl_q.c
    && flags_o.v == fl_q.v && (!uns_q || flags_o.n == fl_q.n)) else $error("multiply touched a kept flag");
  mul_busy_min_a: assert property (acc && is_mul |=> busy_o [*6])
    else $error("multiply finished too early");
  neg_result_a: assert property (acc && is_neg |-> ##2 done_o && wr_a_o.data == -$past(dst_reg_i, 2)
    && flags_o.c == ($past(dst_reg_i, 2) != 0) && flags_o.v == ($past(dst_reg_i, 2) == HMN_MOST_NEG))
    else $error("negate result or flags wrong");
  low_copy_a: assert property (acc && is_lo |-> ##2 wr_a_o.data == {$past(dst_reg_i[31:16], 2),
    $past(src_reg_i[15:0], 2)}) else $error("low half copy wrong");
  high_copy_a: assert property (acc && is_hi |-> ##2 wr_a_o.data == {$past(src_reg_i[31:16], 2),
    $past(dst_reg_i[15:0], 2)}) else $error("high half copy wrong");
  copy_flags_a: assert property (acc && (is_lo || is_hi) |-> ##2 done_o
    && (!flags_we_o || flags_o == $past(flags_i, 2))) else $error("half copy changed flags");
  idle_quiet_a: assert property (acc && is_idle |-> ##2 done_o && pc_advance_o && !wr_a_o.en
    && !wr_b_o.en && (!flags_we_o || flags_o == $past(flags_i, 2))) else $error("idle changed state");
  decode_fields_a: assert property (acc |=> dec_o.rs == $past(opcode_i[8:5])
    && dec_o.rd == $past(opcode_i[3:0]) && dec_o.file_b == $past(opcode_i[4])) else $error("decode fields wrong");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  cover property (acc && is_mul && !opcode_i[0]);
  cover property (acc && opcode_i[15:5] == HMN_COMPLEMENT_BORROW_TOP && flags_i.c);
  cover property (acc && done_o);
endmodule

//--- sim/hmn_regfile_model.sv
`timescale 1ns/1ps
module hmn_regfile_model
  import hmn_pkg::*;
(
  // clock
  input  wire logic           clk_i,
  // operand fetch
  input  wire logic [15:0]    opcode_i,
  output logic [31:0]         src_reg_o,
  output logic [31:0]         dst_reg_o,
  output hmn_pkg::hmn_flags_t flags_o,
  // write-back
  input  hmn_pkg::hmn_wr_t    wr_a_i,
  input  hmn_pkg::hmn_wr_t    wr_b_i,
  input  wire logic           flags_we_i,
  input  hmn_pkg::hmn_flags_t flags_i
);
  logic [31:0] rf [0:31];
  hmn_flags_t  st;
  // one file bit selects both operands
  assign src_reg_o = rf[{opcode_i[4], opcode_i[8:5]}];
  assign dst_reg_o = rf[{opcode_i[4], opcode_i[3:0]}];
  assign flags_o   = st;
  always @(posedge clk_i)
  begin
    if (wr_a_i.en)
      rf[{wr_a_i.file_b, wr_a_i.num}] <= wr_a_i.data;
    if (wr_b_i.en)
      rf[{wr_b_i.file_b, wr_b_i.num}] <= wr_b_i.data;
    if (flags_we_i)
      st <= flags_i;
  end
endmodule

//--- sim/half_move_multiply_negate_unit_tb_top.sv
`timescale 1ns/1ps
module half_move_multiply_negate_unit_tb_top;
  import hmn_pkg::*;
  logic       clk_i, rstn_i, issue_i, long_case_i, flags_we, pc_adv, busy, done;
  logic [15:0] opcode_i;
  logic [5:0]  width, states;
  logic [31:0] src_reg, dst_reg;
  hmn_flags_t  fl_cur, flags_o;
  hmn_dec_t    dec;
  hmn_wr_t     wr_a, wr_b;
  int          miscompares, n_tests;
  hmn_unit #(.DATA_W(32)) i_hmn_unit (.clk_i(clk_i), .rstn_i(rstn_i), .issue_i(issue_i), .opcode_i(opcode_i),
    .long_case_i(long_case_i), .multiplier_width_setting_i(width), .src_reg_i(src_reg), .dst_reg_i(dst_reg),
    .flags_i(fl_cur), .dec_o(dec), .wr_a_o(wr_a), .wr_b_o(wr_b), .flags_we_o(flags_we), .flags_o(flags_o),
    .pc_advance_o(pc_adv), .busy_o(busy), .done_o(done), .states_o(states));
  hmn_regfile_model i_hmn_regfile_model (.clk_i(clk_i), .opcode_i(opcode_i), .src_reg_o(src_reg),
    .dst_reg_o(dst_reg), .flags_o(fl_cur), .wr_a_i(wr_a), .wr_b_i(wr_b), .flags_we_i(flags_we), .flags_i(flags_o));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // ==========================================================
  // one instruction: reference result, issue, bounded wait, compare
  task automatic run(input logic [15:0] op, input logic [31:0] s, input logic [31:0] d,
                     input logic [5:0] n, input logic lc, input hmn_flags_t f);
    logic [63:0] a, m, p;
    logic [31:0] ra, rb;
    logic        mul, uns, pair, bw;
    hmn_flags_t  ef;
    int          k, c;
    mul  = op[15:10] == HMN_SIGNED_MULTIPLY_TOP[6:1];
    uns  = op[15:9] == HMN_UNSIGNED_MULTIPLY_TOP;
    pair = mul && !op[0];
    ef   = f;
    rb   = 32'h0;
    ra   = d;
    k    = 1;
    if (mul)
    begin
      a = uns ? {32'h0, d} : {{32{d[31]}}, d};
      m = {32'h0, s} & ((64'h1 << n) - 64'h1);
      if (!uns && s[n-1])
        m = m | ~((64'h1 << n) - 64'h1);
      p = a * m;
      ra = pair ? p[63:32] : p[31:0];
      rb = p[31:0];
      ef.z = pair ? (p == 64'h0) : (p[31:0] == 32'h0);
      if (!uns)
        ef.n = pair ? p[63] : p[31];
      k = (lc ? 8 : 5) + int'(n) / 2 + int'(uns && s[31]);
    end
    else if (op[15:9] == HMN_LOW_HALF_COPY_TOP)
      ra = {d[31:16], s[15:0]};
    else if (op[15:9] == HMN_HIGH_HALF_COPY_TOP)
      ra = {s[31:16], d[15:0]};
    else if (op != HMN_IDLE_INSTRUCTION)
    begin
      bw = (op[15:5] == HMN_COMPLEMENT_BORROW_TOP) && f.c;
      ra = 32'h0 - d - {31'h0, bw};
      ef = {ra[31], (d != 32'h0) || bw, ra == 32'h0, d[31] & ra[31]};
    end
    i_hmn_regfile_model.rf[{op[4], op[8:5]}] = s;
    i_hmn_regfile_model.rf[{op[4], op[3:0]}] = d;
    i_hmn_regfile_model.st = f;
    opcode_i = op;
    width = n;
    long_case_i = lc;
    issue_i = 1'b1;
    @(posedge clk_i);
    #1;
    issue_i = 1'b0;
    c = 0;
    while (done !== 1'b1 && c < 100)
    begin
      @(posedge clk_i);
      #1;
      c++;
    end
    if (c >= 100)
    begin
      miscompares++;
      final_report();
    end
    check(64'(c), 64'(k));
    check(64'(states), 64'(k));
    check(64'(pc_adv), 64'h1);
    check(64'(wr_a.en), 64'(op != HMN_IDLE_INSTRUCTION));
    if (op != HMN_IDLE_INSTRUCTION)
      check(64'({wr_a.file_b, wr_a.num, wr_a.data}), 64'({op[4], op[3:0], ra}));
    check(64'(wr_b.en), 64'(pair));
    if (pair)
      check(64'({wr_b.file_b, wr_b.num, wr_b.data}), 64'({op[4], op[3:1], 1'b1, rb}));
    check(64'(flags_we ? flags_o : f), 64'(ef));
  endtask
  initial
  begin
    repeat (50000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
  initial
  begin
    hmn_flags_t  f;
    logic [3:0]  rd;
    logic        fb;
    logic [31:0] d;
    logic [31:0] vals [6];
    miscompares = 0;
    n_tests = 0;
    issue_i = 1'b0;
    opcode_i = 16'h0000;
    width = 6'h20;
    long_case_i = 1'b0;
    rstn_i = 1'b0;
    vals = '{32'h0000_0000, 32'h8000_0000, 32'h7fff_ffff, 32'h8000_0001, 32'hffff_ffff, 32'h5555_5555};
    void'($urandom(5362));
    repeat (12) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    // half copies, negates and idle, each after the first issued in the previous done cycle
    for (int i = 0; i < 12; i++)
    begin
      f = 4'($urandom);
      f.c = i[0];
      d = (i < 6) ? vals[i] : $urandom;
      rd = 4'($urandom_range(0, 13));
      fb = 1'($urandom);
      run({HMN_LOW_HALF_COPY_TOP, rd ^ 4'h5, fb, rd}, $urandom, d, 6'h20, 1'b0, f);
      run({HMN_HIGH_HALF_COPY_TOP, rd ^ 4'h5, fb, rd}, $urandom, d, 6'h20, 1'b0, f);
      run({HMN_TWOS_COMPLEMENT_TOP, fb, rd}, 32'h0, d, 6'h20, 1'b0, f);
      run({HMN_COMPLEMENT_BORROW_TOP, fb, rd}, 32'h0, d, 6'h20, 1'b0, f);
      run(HMN_IDLE_INSTRUCTION, $urandom, $urandom, 6'h20, 1'b0, f);
    end
    // both multiplies at every legal width, even and odd destinations
    for (int n = 2; n <= 32; n += 2)
      for (int j = 0; j < 4; j++)
      begin
        rd = 4'($urandom_range(0, 13));
        rd[0] = j[0];
        fb = 1'($urandom);
        run({j[1] ? HMN_UNSIGNED_MULTIPLY_TOP : HMN_SIGNED_MULTIPLY_TOP, rd ^ 4'h6, fb, rd},
            $urandom, $urandom, 6'(n), 1'($urandom), 4'($urandom));
      end
    final_report();
  end
endmodule
bind hmn_unit hmn_unit_props #(.DATA_W(DATA_W)) i_hmn_unit_props (.clk_i(clk_i), .rstn_i(rstn_i),
  .issue_i(issue_i), .opcode_i(opcode_i), .long_case_i(long_case_i),
  .multiplier_width_setting_i(multiplier_width_setting_i), .src_reg_i(src_reg_i), .dst_reg_i(dst_reg_i),
  .flags_i(flags_i), .dec_o(dec_o), .wr_a_o(wr_a_o), .wr_b_o(wr_b_o), .flags_we_o(flags_we_o),
  .flags_o(flags_o), .pc_advance_o(pc_advance_o), .busy_o(busy_o), .done_o(done_o), .states_o(states_o));
